// ### src/aft_afc_tone_ctrl.sv
// afc bias estimator, rx oscillator correction and fsk tone sequencer
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "aft_defines.svh"

module aft_afc_tone_ctrl (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [4:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdData,
    input  wire aft_pkg::aft_disc_type disc,
    input  wire logic        frameStart,
    input  wire logic        txBitEn,
    input  wire logic        txBit,
    output logic      [16:0] rxNcoWord,
    output logic      [16:0] txNcoWord,
    output logic             txShaping
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    aft_pkg::aft_ctrl_type     ctrl_q, ctrl_d;
    logic signed [7:0]         thresh_q, thresh_d;
    logic signed [15:0]        acc_q, acc_d;
    logic signed [15:0]        biasHw_q, biasHw_d;
    logic signed [15:0]        biasSw_q, biasSw_d;
    logic        [15:0]        rxNominal_q, rxNominal_d;
    logic        [15:0]        txCentre_q, txCentre_d;
    logic        [15:0]        txDev_q, txDev_d;
    logic        [15:0]        stepDiv_q, stepDiv_d;
    logic        [15:0]        rdData_q, rdData_d;
    logic        [16:0]        rxNco_q, rxNco_d;
    logic        [16:0]        txNco_q, txNco_d;
    aft_pkg::aft_tx_state_type txState_q, txState_d;
    logic        [2:0]         stepCnt_q, stepCnt_d;
    logic        [15:0]        divCnt_q, divCnt_d;
    logic                      curBit_q, curBit_d;

    logic                      sampleHit;
    logic signed [15:0]        sampleExt;
    logic signed [15:0]        biasSel;
    logic signed [15:0]        devSel;
    logic                      tableWr;
    logic        [15:0]        shapeData;

    ////////////////////////////////////////////////////////////////////////////
    // register writes

    // software-owned settings; unmapped writes are dropped
    always_comb begin
        ctrl_d      = ctrl_q;
        thresh_d    = thresh_q;
        biasSw_d    = biasSw_q;
        rxNominal_d = rxNominal_q;
        txCentre_d  = txCentre_q;
        txDev_d     = txDev_q;
        stepDiv_d   = stepDiv_q;
        tableWr     = 1'h0;
        if (regWr) begin
            if ((regAddr & `AFT_REG_SHAPE_MASK) == `AFT_REG_SHAPE_BASE) begin
                tableWr = 1'h1;
            end
            unique case (regAddr)
                `AFT_REG_CTRL: begin
                    ctrl_d.biasEnable  = regWrData[`AFT_CTRL_EN_BIT];
                    ctrl_d.useCoreBias = regWrData[`AFT_CTRL_SRC_BIT];
                    // more than four steps is clamped, the table holds four entries per bit value
                    ctrl_d.shapeSteps  =
                        (regWrData[`AFT_CTRL_STEPS_MSB:`AFT_CTRL_STEPS_LSB] > `AFT_MAX_STEPS)
                        ? `AFT_MAX_STEPS
                        : regWrData[`AFT_CTRL_STEPS_MSB:`AFT_CTRL_STEPS_LSB];
                end
                `AFT_REG_THRESH:     thresh_d    = regWrData[7:0];
                `AFT_REG_BIAS_SW:    biasSw_d    = regWrData;
                `AFT_REG_RX_NOMINAL: rxNominal_d = regWrData;
                `AFT_REG_TX_CENTRE:  txCentre_d  = regWrData;
                `AFT_REG_TX_DEV:     txDev_d     = regWrData;
                `AFT_REG_STEP_DIV:   stepDiv_d   = regWrData;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q      <= aft_pkg::aft_ctrl_type'(`AFT_CTRL_RST);
            thresh_q    <= `AFT_THRESH_RST;
            biasSw_q    <= 16'h0000;
            rxNominal_q <= `AFT_RX_NOMINAL_RST;
            txCentre_q  <= `AFT_TX_CENTRE_RST;
            txDev_q     <= `AFT_TX_DEV_RST;
            stepDiv_q   <= `AFT_STEP_DIV_RST;
        end else begin
            ctrl_q      <= ctrl_d;
            thresh_q    <= thresh_d;
            biasSw_q    <= biasSw_d;
            rxNominal_q <= rxNominal_d;
            txCentre_q  <= txCentre_d;
            txDev_q     <= txDev_d;
            stepDiv_q   <= stepDiv_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bias estimator and rx oscillator word

    assign sampleExt = {{8{disc.value[7]}}, disc.value};
    assign sampleHit = disc.valid && (disc.value > thresh_q);

    // accumulate during the frame, hand the sum over at frame start
    always_comb begin
        acc_d    = acc_q;
        biasHw_d = biasHw_q;
        if (frameStart) begin
            biasHw_d = acc_q;
            if (ctrl_q.biasEnable) begin
                acc_d = sampleHit ? sampleExt : 16'sh0000;
            end
        end else if (ctrl_q.biasEnable && sampleHit) begin
            acc_d = acc_q + sampleExt;
        end
    end

    // the latched estimate, not the live sum, steers the oscillator so it holds still
    assign biasSel = ctrl_q.useCoreBias ? biasSw_q : biasHw_q;
    assign rxNco_d = {1'h0, rxNominal_q} + {biasSel[15], biasSel};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_q    <= 16'sh0000;
            biasHw_q <= 16'sh0000;
            rxNco_q  <= 17'h00000;
        end else begin
            acc_q    <= acc_d;
            biasHw_q <= biasHw_d;
            rxNco_q  <= rxNco_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fsk tone sequencer

    // a new bit restarts shaping even mid-sequence; steps pace on a divider pulse
    always_comb begin
        txState_d = txState_q;
        stepCnt_d = stepCnt_q;
        divCnt_d  = divCnt_q;
        curBit_d  = curBit_q;
        if (txBitEn && (txBit != curBit_q)) begin
            curBit_d  = txBit;
            stepCnt_d = 3'h0;
            divCnt_d  = stepDiv_q;
            txState_d = (ctrl_q.shapeSteps != 3'h0) ? aft_pkg::TX_SHAPE : aft_pkg::TX_STEADY;
        end else begin
            unique case (txState_q)
                aft_pkg::TX_STEADY: begin
                end
                aft_pkg::TX_SHAPE: begin
                    if (divCnt_q == 16'h0000) begin
                        divCnt_d = stepDiv_q;
                        if ((stepCnt_q + 3'h1) >= ctrl_q.shapeSteps) begin
                            txState_d = aft_pkg::TX_STEADY;
                        end else begin
                            stepCnt_d = stepCnt_q + 3'h1;
                        end
                    end else begin
                        divCnt_d = divCnt_q - 16'h0001;
                    end
                end
            endcase
        end
    end

    // table entries are signed offsets from the centre
    assign devSel  = (txState_q == aft_pkg::TX_SHAPE) ? shapeData
                   : (curBit_q ? txDev_q : (16'h0000 - txDev_q));
    assign txNco_d = {1'h0, txCentre_q} + {devSel[15], devSel};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            txState_q <= aft_pkg::TX_STEADY;
            stepCnt_q <= 3'h0;
            divCnt_q  <= 16'h0000;
            curBit_q  <= 1'h0;
            txNco_q   <= 17'h00000;
        end else begin
            txState_q <= txState_d;
            stepCnt_q <= stepCnt_d;
            divCnt_q  <= divCnt_d;
            curBit_q  <= curBit_d;
            txNco_q   <= txNco_d;
        end
    end

    // read address follows the next state so data lines up with the state register
    aft_shape_mem shapeMem (
        .clk    (clk),
        .resetn (resetn),
        .wrEn   (tableWr),
        .wrAddr (regAddr[2:0]),
        .wrData (regWrData),
        .rdAddr ({curBit_d, stepCnt_d[1:0]}),
        .rdData (shapeData)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register reads

    // data stand only in the cycle after the strobe, zero otherwise
    always_comb begin
        rdData_d = 16'h0000;
        if (regRd) begin
            unique case (regAddr)
                `AFT_REG_CTRL:       rdData_d = {11'h000, ctrl_q};
                `AFT_REG_THRESH:     rdData_d = {{8{thresh_q[7]}}, thresh_q};
                `AFT_REG_BIAS_HW:    rdData_d = biasHw_q;
                `AFT_REG_BIAS_SW:    rdData_d = biasSw_q;
                `AFT_REG_RX_NOMINAL: rdData_d = rxNominal_q;
                `AFT_REG_TX_CENTRE:  rdData_d = txCentre_q;
                `AFT_REG_TX_DEV:     rdData_d = txDev_q;
                `AFT_REG_STEP_DIV:   rdData_d = stepDiv_q;
                `AFT_REG_STATUS:     rdData_d = {11'h000, stepCnt_q, txState_q, curBit_q};
                `AFT_REG_ACC_LIVE:   rdData_d = acc_q;
                default:             rdData_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdData_q <= 16'h0000;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    assign regRdData = rdData_q;
    assign rxNcoWord = rxNco_q;
    assign txNcoWord = txNco_q;
    assign txShaping = txState_q;

endmodule

// ### src/aft_defines.svh
// register offsets, field positions, reset values and tone constants of the afc/tone block
`ifndef AFT_DEFINES_SVH
`define AFT_DEFINES_SVH

// register word indices on the plain register port
`define AFT_REG_CTRL       5'h00
`define AFT_REG_THRESH     5'h01
`define AFT_REG_BIAS_HW    5'h02
`define AFT_REG_BIAS_SW    5'h03
`define AFT_REG_RX_NOMINAL 5'h04
`define AFT_REG_TX_CENTRE  5'h05
`define AFT_REG_TX_DEV     5'h06
`define AFT_REG_STEP_DIV   5'h07
`define AFT_REG_STATUS     5'h08
`define AFT_REG_ACC_LIVE   5'h09
`define AFT_REG_SHAPE_BASE 5'h10
`define AFT_REG_SHAPE_MASK 5'h18

// control register fields
`define AFT_CTRL_EN_BIT    0
`define AFT_CTRL_SRC_BIT   1
`define AFT_CTRL_STEPS_LSB 2
`define AFT_CTRL_STEPS_MSB 4
`define AFT_MAX_STEPS      3'h4

// reset values: 460 kHz in 125 Hz units, 2.508 MHz and 32.56 kHz in 62.5 Hz units
`define AFT_CTRL_RST       5'h00
`define AFT_THRESH_RST     8'h00
`define AFT_RX_NOMINAL_RST 16'h0e60
`define AFT_TX_CENTRE_RST  16'h9cc0
`define AFT_TX_DEV_RST     16'h0209
`define AFT_STEP_DIV_RST   16'h0010

`endif

// ### src/aft_pkg.sv
// types shared by the afc loop and fsk tone control block
package aft_pkg;

    // software controls of the bias path and shaper
    typedef struct packed {
        logic [2:0] shapeSteps;
        logic       useCoreBias;
        logic       biasEnable;
    } aft_ctrl_type;

    // one discriminator sample with its qualifier
    typedef struct packed {
        logic              valid;
        logic signed [7:0] value;
    } aft_disc_type;

    typedef enum logic [0:0] {
        TX_STEADY = 1'h0,
        TX_SHAPE  = 1'h1
    } aft_tx_state_type;

endpackage

// ### src/aft_shape_mem.sv
// small table of intermediate deviation values, registered read
`timescale 1ns/1ps
`include "aft_defines.svh"

module aft_shape_mem (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        wrEn,
    input  wire logic [2:0]  wrAddr,
    input  wire logic [15:0] wrData,
    input  wire logic [2:0]  rdAddr,
    output logic      [15:0] rdData
);

    logic [15:0] table_q [0:7];
    logic [15:0] rdData_q;

    // entries are software-owned, so no reset is spent on them
    always_ff @(posedge clk) begin
        if (wrEn) begin
            table_q[wrAddr] <= wrData;
        end
    end

    // read data from a register keeps the tone adder path short
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdData_q <= 16'h0000;
        end else begin
            rdData_q <= table_q[rdAddr];
        end
    end

    assign rdData = rdData_q;

endmodule

// ### testbench/aft_core_model.sv
// register-port master standing in for the dsp core
`timescale 1ns/1ps
module aft_core_model (
    input  wire logic        clk,
    input  wire logic [15:0] regRdData,
    output logic      [4:0]  regAddr,
    output logic      [15:0] regWrData,
    output logic             regWr,
    output logic             regRd
);
    // bus idle from time zero so reset never sees a stray strobe
    initial begin
        regAddr = 5'h00;
        regWrData = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    ////////////////////////////////////////
    // one-cycle write; released data lines show the inverse so stale data cannot pass
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        #1;
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        regWrData <= ~d;
    endtask
    // one-cycle read, data taken in the one cycle where it stands
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        #1;
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        regAddr <= ~a;
        #1;
        d = regRdData;
    endtask
endmodule

// ### testbench/aft_tone_props.sv
// port assertions for the afc loop and tone control block
`timescale 1ns/1ps
`include "aft_defines.svh"
module aft_tone_props (
    input wire logic                  clk,
    input wire logic                  resetn,
    input wire logic [4:0]            regAddr,
    input wire logic [15:0]           regWrData,
    input wire logic                  regWr,
    input wire logic                  regRd,
    input wire logic [15:0]           regRdData,
    input wire aft_pkg::aft_disc_type disc,
    input wire logic                  frameStart,
    input wire logic                  txBitEn,
    input wire logic                  txBit,
    input wire logic [16:0]           rxNcoWord,
    input wire logic [16:0]           txNcoWord,
    input wire logic                  txShaping
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    // read data only in the cycle after a read strobe
    rd_idle_a:
        assert property (!$past(regRd) |-> regRdData == 16'h0000) else $error("stray read data");
    // rx word moves only two edges after a write or a frame latch; the release edge is skipped
    rx_hold_a:
        assert property (resetn && !regWr && !frameStart |-> ##2 $stable(rxNcoWord))
            else $error("rx word moved");
    // a write to the read-only estimate leaves the rx word alone
    hw_ro_a:
        assert property (regWr && regAddr == `AFT_REG_BIAS_HW && !frameStart |-> ##2
            $stable(rxNcoWord)) else $error("read-only estimate took a write");
    // tx word only follows a write, a bit change or a shaping step
    tx_hold_a:
        assert property (resetn && !regWr && !txBitEn && !txShaping |-> ##2 $stable(txNcoWord))
            else $error("tx word moved");
    sw_rb_a:
        assert property (regWr && regAddr == `AFT_REG_BIAS_SW ##1 regRd && regAddr ==
            `AFT_REG_BIAS_SW |=> regRdData == $past(regWrData, 2)) else $error("sw bias lost");
    // threshold reads back sign-extended from its low byte
    thr_rb_a:
        assert property (regWr && regAddr == `AFT_REG_THRESH ##1 regRd && regAddr ==
            `AFT_REG_THRESH |=> regRdData == {{8{$past(regWrData[7], 2)}},
            $past(regWrData[7:0], 2)}) else $error("threshold readback wrong");
    shape_wo_a:
        assert property (regRd && regAddr[4:3] == 2'h2 |=> regRdData == 16'h0000)
            else $error("shape table readable");
    shape_cause_a:
        assert property ($rose(txShaping) |-> $past(txBitEn) || $past(txBitEn, 2))
            else $error("shaping without bit event");
endmodule
bind aft_afc_tone_ctrl aft_tone_props aft_tone_props_inst (.clk(clk), .resetn(resetn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .disc(disc), .frameStart(frameStart), .txBitEn(txBitEn),
    .txBit(txBit), .rxNcoWord(rxNcoWord), .txNcoWord(txNcoWord), .txShaping(txShaping));

// ### testbench/tb.sv
// self-checking bench for the afc loop and fsk tone control block
`timescale 1ns/1ps
`include "aft_defines.svh"
module tb;
    logic [4:0]            regAddr;
    logic [15:0]           regWrData;
    logic [15:0]           regRdData;
    aft_pkg::aft_disc_type disc;
    logic [16:0]           rxNcoWord;
    logic [16:0]           txNcoWord;
    logic clk, resetn, regWr, regRd, frameStart, txBitEn, txBit, txShaping;
    int          errCount, samplesChecked, cyc, acc, thr, cnt;
    logic [15:0] rd, hw, sw;
    logic [15:0] tab [8];
    logic [16:0] seen [$];
    logic [16:0] want [$];
    localparam logic [16:0] CEN = 17'h09cc0;
    localparam logic [16:0] DEV = 17'h00209;
    aft_afc_tone_ctrl aft_afc_tone_ctrl_inst (.clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .disc(disc), .frameStart(frameStart), .txBitEn(txBitEn), .txBit(txBit),
        .rxNcoWord(rxNcoWord), .txNcoWord(txNcoWord), .txShaping(txShaping));
    aft_core_model aft_core_model_inst (.clk(clk), .regRdData(regRdData), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd));
    ////////////////////////////////////////
    task automatic check(input logic [16:0] s, input logic [16:0] e);
        samplesChecked++;
        if (s !== e) begin
            errCount++;
            $display("ERROR %0t: saw %h, wanted %h", $time, s, e);
        end
    endtask
    task automatic stopTest();
        if (errCount == 0 && samplesChecked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic w(input logic [4:0] a, input logic [15:0] d);
        aft_core_model_inst.wr(a, d);
    endtask
    task automatic r(input logic [4:0] a, output logic [15:0] d);
        aft_core_model_inst.rd(a, d);
    endtask
    // random samples; the model sums the valid ones above threshold while counting
    task automatic send(input int n, input bit on);
        logic [7:0] v;
        logic       q;
        repeat (n) begin
            v = 8'($urandom);
            q = 1'($urandom);
            @(posedge clk);
            disc <= '{valid: q, value: v};
            if (on && q && $signed(v) > thr) acc += $signed(v);
        end
        @(posedge clk);
        disc <= '0;
    endtask
    // flip the data bit and log each distinct tx word and the shaping length
    task automatic flip(input logic b);
        seen.delete();
        cnt = 0;
        @(posedge clk);
        txBit <= b;
        txBitEn <= 1'b1;
        repeat (15) begin
            @(posedge clk);
            txBitEn <= 1'b0;
            #1;
            cnt += int'(txShaping === 1'b1);
            if (seen.size() == 0 || seen[$] !== txNcoWord) seen.push_back(txNcoWord);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ceiling far above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errCount++;
            stopTest();
        end
    end
    initial begin
        {errCount, samplesChecked, cyc, acc} = '0;
        {resetn, frameStart, txBitEn, txBit} = '0;
        disc = '0;
        void'($urandom(36686));
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        check(rxNcoWord, 17'h00e60);
        check(txNcoWord, CEN - DEV);
        w(`AFT_REG_TX_CENTRE, 16'h9cc0);
        w(`AFT_REG_TX_DEV, 16'h0209);
        thr = int'($urandom_range(40)) - 20;
        w(`AFT_REG_THRESH, 16'(thr));
        r(`AFT_REG_THRESH, rd);
        check({1'b0, rd}, {1'b0, 16'(thr)});
        w(`AFT_REG_CTRL, 16'h0001);
        send(60, 1'b1);
        r(`AFT_REG_ACC_LIVE, rd);
        check({1'b0, rd}, {1'b0, 16'(acc)});
        // enable dropped: the live sum holds through more samples
        w(`AFT_REG_CTRL, 16'h0000);
        send(30, 1'b0);
        r(`AFT_REG_ACC_LIVE, rd);
        check({1'b0, rd}, {1'b0, 16'(acc)});
        @(posedge clk);
        frameStart <= 1'b1;
        @(posedge clk);
        frameStart <= 1'b0;
        hw = 16'(acc);
        r(`AFT_REG_BIAS_HW, rd);
        check({1'b0, rd}, {1'b0, hw});
        check(rxNcoWord, 17'h00e60 + {hw[15], hw});
        // software bias takes over; the estimate ignores writes
        sw = 16'($urandom);
        w(`AFT_REG_BIAS_SW, sw);
        r(`AFT_REG_BIAS_SW, rd);
        check({1'b0, rd}, {1'b0, sw});
        w(`AFT_REG_BIAS_HW, ~hw);
        w(`AFT_REG_CTRL, 16'h0002);
        r(`AFT_REG_BIAS_HW, rd);
        check({1'b0, rd}, {1'b0, hw});
        check(rxNcoWord, 17'h00e60 + {sw[15], sw});
        w(`AFT_REG_STEP_DIV, 16'h0001);
        for (int i = 0; i < 8; i++) begin
            tab[i] = {4'(i + 1), 12'($urandom)};
            w(5'(`AFT_REG_SHAPE_BASE + i), tab[i]);
        end
        r(`AFT_REG_SHAPE_BASE, rd);
        check({1'b0, rd}, 17'h00000);
        // depth 0 is a plain jump; depth 5 must clamp to the four-step limit
        for (int s = 0; s < 6; s++) begin
            w(`AFT_REG_CTRL, 16'(s << 2));
            flip(!s[0]);
            want = {s[0] ? CEN + DEV : CEN - DEV};
            for (int k = 0; k < s && k < 4; k++) begin
                sw = tab[{~s[0], k[1:0]}];
                want.push_back(CEN + {sw[15], sw});
            end
            want.push_back(s[0] ? CEN - DEV : CEN + DEV);
            check(17'(seen.size()), 17'(want.size()));
            foreach (want[i]) check(seen[i], want[i]);
            check(17'(cnt), 17'(2 * (s > 4 ? 4 : s)));
        end
        // new nominal word, then an enabled frame start: sum handed over, restarted at zero
        sw = 16'($urandom);
        w(`AFT_REG_RX_NOMINAL, sw);
        w(`AFT_REG_CTRL, 16'h0001);
        @(posedge clk);
        frameStart <= 1'h1;
        @(posedge clk);
        frameStart <= 1'h0;
        r(`AFT_REG_ACC_LIVE, rd);
        check({1'h0, rd}, 17'h00000);
        r(`AFT_REG_BIAS_HW, rd);
        check({1'h0, rd}, {1'h0, hw});
        check(rxNcoWord, {1'h0, sw} + {hw[15], hw});
        // last flip sent a zero and shaping has ended
        r(`AFT_REG_STATUS, rd);
        check({1'h0, rd & 16'h0003}, 17'h00000);
        stopTest();
    end
endmodule
